// file: dv/ofs_rx.sv
`timescale 1ns/1ps
// ************************************************************
// pulse receiver on the far side of the pulse output
// ************************************************************
module ofs_rx (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pulse_out,
  output logic      [15:0] cnt
);
  logic last_reg;
  // counts rising edges only, as a totaliser would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 1'b0;
      cnt      <= 16'h0;
    end else begin
      last_reg <= pulse_out;
      if (pulse_out && !last_reg) cnt <= cnt + 16'h1;
    end
  end
endmodule // ofs_rx

// file: dv/ofs_selector_bench.sv
`timescale 1ns/1ps
module ofs_selector_bench;
  import ofs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, fb_live = 32'h5a5a_0001, fb_out, rd_val;
  logic        pready, pslverr, zero_ret_in = 0, supply_ok = 1, relay_req = 1, pulse_live = 1;
  logic        pulse_out, relay_out, irq, last_err;
  logic [1:0]  err_sev = OFS_SEV_NONE;
  logic [15:0] cur_live = 16'h1111, cur_zero = 16'h0064, freq_live = 16'h2222, cur_out, freq_out, cnt, c0;
  logic [15:0] ecur [4] = '{16'h0123, 16'habcd, 16'h1111, 16'h3333};
  logic [15:0] efr [4] = '{16'h0000, 16'h2222, 16'h4444, 16'h0456};
  logic        epl [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  int          n_mismatch = 0, compares = 0;

  always #50 pclk = ~pclk;

  ofs_selector ofs_selector_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .err_sev(err_sev), .zero_ret_in(zero_ret_in), .supply_ok(supply_ok), .relay_req(relay_req),
    .cur_live(cur_live), .cur_zero(cur_zero), .freq_live(freq_live), .pulse_live(pulse_live),
    .fb_live(fb_live), .cur_out(cur_out), .freq_out(freq_out), .pulse_out(pulse_out), .fb_out(fb_out),
    .relay_out(relay_out), .irq(irq));
  ofs_rx ofs_rx_inst (.pclk(pclk), .presetn(presetn), .pulse_out(pulse_out), .cnt(cnt));

  // ************************************************************
  // tasks
  // ************************************************************
  task wrap_up;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // setup cycle, then access until pready; data taken at that edge only
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_mismatch++;
      wrap_up;
    end
    rd_val = prdata; last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(exp, rd_val);
  endtask

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    tick(2);
    presetn <= 1'b1;
    rd(OFS_ADDR_CUR_CFG, 32'h0);
    rd(OFS_ADDR_PF_CFG, 32'h0);
    rd(OFS_ADDR_ALARM_HI, 32'h0000_ffff);
    rd(12'h100, 32'h0);
    chk(32'h1, {31'h0, last_err});
    wr(OFS_ADDR_ALARM_LO, 32'h4000_0123);
    wr(OFS_ADDR_ALARM_HI, 32'h4000_abcd);
    wr(OFS_ADDR_SUBST_FRQ, 32'h0000_0456);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_ADDR_CUR_CFG, 32'(i) | 32'h4);
      wr(OFS_ADDR_PF_CFG, 32'(i) | (32'(i) << 2));
      cur_live <= 16'h1111; freq_live <= 16'h2222;
      pulse_live <= 1'b1;
      tick(2);
      err_sev <= i[0] ? OFS_SEV_SYSTEM : OFS_SEV_FAULT;
      tick(1);
      cur_live <= 16'h3333; freq_live <= 16'h4444;
      pulse_live <= 1'b0;
      tick(2);
      chk({16'h0, ecur[i]}, {16'h0, cur_out});
      chk({16'h0, efr[i]}, {16'h0, freq_out});
      chk({31'h0, epl[i]}, {31'h0, pulse_out});
      chk(32'h0, {31'h0, relay_out});
      err_sev <= OFS_SEV_NONE;
      tick(2);
    end
    $display("test failsafe options done");
    wr(OFS_ADDR_PF_CFG, 32'h0);
    wr(OFS_ADDR_CUR_CFG, 32'h4);
    err_sev <= OFS_SEV_FAULT;
    tick(2);
    c0 = cnt;
    repeat (8) begin
      pulse_live <= ~pulse_live;
      tick(1);
    end
    tick(2);
    chk({16'h0, c0}, {16'h0, cnt});
    err_sev <= OFS_SEV_NOTICE;
    cur_live <= 16'h7777;
    tick(3);
    chk(32'h7777, {16'h0, cur_out});
    chk(32'h1, {31'h0, relay_out});
    $display("test pulse stop and notice done");
    err_sev <= OFS_SEV_NONE;
    wr(OFS_ADDR_IRQ_EN, 32'h0);
    wr(OFS_ADDR_IRQ_CLR, 32'h7);
    rd(OFS_ADDR_IRQ_STAT, 32'h0);
    err_sev <= OFS_SEV_FAULT;
    tick(2);
    chk(32'h0, {31'h0, irq});
    wr(OFS_ADDR_IRQ_EN, 32'h7);
    tick(1);
    chk(32'h1, {31'h0, irq});
    err_sev <= OFS_SEV_NONE;
    tick(2);
    rd(OFS_ADDR_IRQ_STAT, 32'h3);
    wr(OFS_ADDR_IRQ_CLR, 32'h3);
    rd(OFS_ADDR_IRQ_STAT, 32'h0);
    chk(32'h0, {31'h0, irq});
    $display("test interrupts done");
    wr(OFS_ADDR_CUR_CFG, 32'h7);
    wr(OFS_ADDR_CTRL, 32'h1);
    zero_ret_in <= 1'b1;
    err_sev <= OFS_SEV_FAULT;
    tick(3);
    chk({16'h0, cur_zero}, {16'h0, cur_out});
    chk(32'h0, {16'h0, freq_out});
    chk(32'h0, {31'h0, pulse_out});
    chk(32'h0, fb_out);
    rd(OFS_ADDR_IRQ_STAT, 32'h5);
    rd(OFS_ADDR_STATUS, 32'h6);
    err_sev <= OFS_SEV_NONE;
    tick(2);
    chk(32'h1, {31'h0, relay_out});
    zero_ret_in <= 1'b0;
    wr(OFS_ADDR_CTRL, 32'h2);
    tick(2);
    chk(32'h0, fb_out);
    chk({16'h0, cur_zero}, {16'h0, cur_out});
    wr(OFS_ADDR_CTRL, 32'h1);
    tick(2);
    chk(32'h0000_abcd, {16'h0, cur_out});
    chk(32'h0000_0456, {16'h0, freq_out});
    wr(OFS_ADDR_CTRL, 32'h0);
    tick(2);
    chk(fb_live, fb_out);
    supply_ok <= 1'b0;
    tick(2);
    chk(32'h0, {31'h0, relay_out});
    $display("test zero return and relay done");
    wrap_up;
  end
endmodule // ofs_selector_bench

// file: dv/ofs_selector_props.sv
`timescale 1ns/1ps
// ************************************************************
// port checker
// ************************************************************
module ofs_selector_props
  import ofs_pkg::*;
#(
  parameter int CUR_W  = 16,
  parameter int FREQ_W = 16,
  parameter int FB_W   = 32
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [1:0]        err_sev,
  input wire logic              zero_ret_in,
  input wire logic              supply_ok,
  input wire logic              relay_req,
  input wire logic [CUR_W-1:0]  cur_zero,
  input wire logic [CUR_W-1:0]  cur_out,
  input wire logic [FREQ_W-1:0] freq_out,
  input wire logic              pulse_out,
  input wire logic [FB_W-1:0]   fb_out,
  input wire logic              relay_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ZR_CUR: assert property (zero_ret_in |=> cur_out == $past(cur_zero))
    else $error("current not at zero-flow code under override");
  AST_ZR_FREQ: assert property (zero_ret_in |=> freq_out == '0)
    else $error("frequency not zero under override");
  AST_ZR_PULSE: assert property (zero_ret_in |=> !pulse_out)
    else $error("pulse seen under override");
  AST_ZR_FB: assert property (zero_ret_in |=> fb_out == '0)
    else $error("fieldbus value not zero under override");
  AST_RELAY_OFF: assert property ((!supply_ok || err_sev[1]) |=> !relay_out)
    else $error("relay energized during fault or supply loss");
  AST_RELAY_ZR: assert property ((relay_req && supply_ok && !err_sev[1] && zero_ret_in) |=> relay_out)
    else $error("override changed the relay");
  AST_NOTICE: assert property ((err_sev == OFS_SEV_NOTICE && relay_req && supply_ok) |=> relay_out)
    else $error("notice changed the relay");
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("access phase not answered");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  CV_ZR: cover property (zero_ret_in ##1 !zero_ret_in);
  CV_FAULT: cover property (err_sev[1] ##1 !relay_out);
  CV_ERR: cover property (pslverr);
endmodule // ofs_selector_props

bind ofs_selector ofs_selector_props #(.CUR_W(CUR_W), .FREQ_W(FREQ_W), .FB_W(FB_W)) ofs_selector_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .err_sev(err_sev), .zero_ret_in(zero_ret_in), .supply_ok(supply_ok), .relay_req(relay_req),
  .cur_zero(cur_zero), .cur_out(cur_out), .freq_out(freq_out), .pulse_out(pulse_out), .fb_out(fb_out),
  .relay_out(relay_out));

// file: src/ofs_chan.sv
`timescale 1ns/1ps
// one output channel: selects live, frozen, substitute or zero value
module ofs_chan
  import ofs_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] live_val,
  input  wire logic [W-1:0] fail_val,
  input  wire logic [W-1:0] sim_val,
  input  wire logic [W-1:0] zero_val,
  input  wire logic         sim_en,
  input  wire logic         fail_act,
  input  wire logic         zero_ret,
  input  wire logic [1:0]   opt,
  output logic [W-1:0]      out_val
);

  if (W < 1) begin : g_bad_w
    $error("ofs_chan: W must be positive");
  end

  logic [W-1:0] hold_reg;
  logic [W-1:0] src_w;
  logic [W-1:0] sel_w;
  logic [W-1:0] out_next;

  // frozen copy tracks the source value (live, or simulated when sim_en) only while healthy
  assign src_w = sim_en ? sim_val : live_val;
  assign sel_w = (opt == OFS_FREEZE)    ? hold_reg :
                 (opt == OFS_PASS_LIVE) ? src_w    :
                 fail_val;
  assign out_next = zero_ret ? zero_val :
                    fail_act ? sel_w : src_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= '0;
      out_val  <= '0;
    end else begin
      if (!fail_act) hold_reg <= src_w;
      out_val <= out_next;
    end
  end

endmodule // ofs_chan

// file: src/ofs_irq.sv
`timescale 1ns/1ps
// sticky event bits; a set in the cycle of a clear wins
module ofs_irq
  import ofs_pkg::*;
#(
  parameter int N = OFS_IRQ_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] ev,
  input  wire logic [N-1:0] clr,
  input  wire logic [N-1:0] en,
  output logic [N-1:0]      stat_reg,
  output logic              irq
);

  if (N < 1) begin : g_bad_n
    $error("ofs_irq: N must be positive");
  end

  logic [N-1:0] stat_next;

  assign stat_next = (stat_reg & ~clr) | ev;
  assign irq = |(stat_reg & en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat_reg <= '0;
    else stat_reg <= stat_next;
  end

endmodule // ofs_irq

// file: src/ofs_pkg.sv
package ofs_pkg;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] OFS_ADDR_CUR_CFG   = 12'h000;
  localparam logic [11:0] OFS_ADDR_PF_CFG    = 12'h004;
  localparam logic [11:0] OFS_ADDR_SUBST_FRQ = 12'h008;
  localparam logic [11:0] OFS_ADDR_CTRL      = 12'h00c;
  localparam logic [11:0] OFS_ADDR_STATUS    = 12'h010;
  localparam logic [11:0] OFS_ADDR_IRQ_STAT  = 12'h014;
  localparam logic [11:0] OFS_ADDR_IRQ_EN    = 12'h018;
  localparam logic [11:0] OFS_ADDR_IRQ_CLR   = 12'h01c;
  localparam logic [11:0] OFS_ADDR_ALARM_LO  = 12'h020;
  localparam logic [11:0] OFS_ADDR_ALARM_HI  = 12'h024;

  // ************************************************************
  // failsafe options
  // ************************************************************
  typedef enum logic [1:0] {
    OFS_GO_DEFAULT = 2'h0,
    OFS_FREEZE     = 2'h1,
    OFS_PASS_LIVE  = 2'h2,
    OFS_FIXED_FREQ = 2'h3
  } ofs_opt_e;

  // current output: 0 low alarm, 1 high alarm, 2 freeze, 3 pass_live
  localparam logic [1:0] OFS_CUR_LOW_ALARM  = 2'h0;
  localparam logic [1:0] OFS_CUR_HIGH_ALARM = 2'h1;
  localparam logic [1:0] OFS_CUR_FREEZE     = 2'h2;
  localparam logic [1:0] OFS_CUR_PASS_LIVE  = 2'h3;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int OFS_PF_PULSE_LSB  = 0;
  localparam int OFS_PF_FREQ_LSB   = 2;
  localparam int OFS_CUR_OPT_LSB   = 0;
  localparam int OFS_CUR_RANGE_LSB = 2;
  localparam int OFS_RANGE_W       = 2;
  localparam int OFS_N_RANGE       = 1 << OFS_RANGE_W;
  localparam int OFS_ALARM_IDX_LSB = 30;
  localparam int OFS_CTRL_SIM_BIT  = 0;
  localparam int OFS_CTRL_ZR_BIT   = 1;
  localparam int OFS_IRQ_W         = 3;
  localparam int OFS_IRQ_FAIL_ON   = 0;
  localparam int OFS_IRQ_FAIL_OFF  = 1;
  localparam int OFS_IRQ_ZR_ON     = 2;

  localparam logic [3:0] OFS_CUR_CFG_RST = 4'h0;
  localparam logic [3:0] OFS_PF_CFG_RST  = 4'h0;

  // error severity classes from the measurement core
  localparam logic [1:0] OFS_SEV_NONE   = 2'h0;
  localparam logic [1:0] OFS_SEV_NOTICE = 2'h1;
  localparam logic [1:0] OFS_SEV_FAULT  = 2'h2;
  localparam logic [1:0] OFS_SEV_SYSTEM = 2'h3;

endpackage

// file: src/ofs_selector.sv
`timescale 1ns/1ps
// ************************************************************
// output failsafe selector
// ************************************************************
module ofs_selector
  import ofs_pkg::*;
#(
  parameter int CUR_W  = 16,
  parameter int FREQ_W = 16,
  parameter int FB_W   = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        err_sev,
  input  wire logic              zero_ret_in,
  input  wire logic              supply_ok,
  input  wire logic              relay_req,
  input  wire logic [CUR_W-1:0]  cur_live,
  input  wire logic [CUR_W-1:0]  cur_zero,
  input  wire logic [FREQ_W-1:0] freq_live,
  input  wire logic              pulse_live,
  input  wire logic [FB_W-1:0]   fb_live,
  output logic [CUR_W-1:0]       cur_out,
  output logic [FREQ_W-1:0]      freq_out,
  output logic                   pulse_out,
  output logic [FB_W-1:0]        fb_out,
  output logic                   relay_out,
  output logic                   irq
);

  // the alarm level shares its write word with the range index above it
  if (CUR_W < 2 || CUR_W > OFS_ALARM_IDX_LSB) begin : g_bad_cur_w
    $error("ofs_selector: CUR_W out of range");
  end
  if (FREQ_W < 2 || FREQ_W > 32) begin : g_bad_freq_w
    $error("ofs_selector: FREQ_W out of range");
  end
  if (FB_W < 1) begin : g_bad_fb_w
    $error("ofs_selector: FB_W out of range");
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [3:0]                   cur_cfg_reg;
  logic [3:0]                   pf_cfg_reg;
  logic [FREQ_W-1:0]            subst_frq_reg;
  logic [1:0]                   ctrl_reg;
  logic [CUR_W-1:0]             alarm_lo_reg [OFS_N_RANGE];
  logic [CUR_W-1:0]             alarm_hi_reg [OFS_N_RANGE];
  logic [OFS_IRQ_W-1:0]         irq_en_reg;
  logic [OFS_IRQ_W-1:0]         irq_stat;
  logic                         fail_d_reg;
  logic                         zr_d_reg;
  logic                         relay_reg;
  logic [FB_W-1:0]              fb_reg;
  logic [31:0]                  prdata_reg;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire wr_en = psel && penable && pwrite;
  // read word is latched at the setup edge, so only the setup phase selects it
  wire rd_en = psel && !penable && !pwrite;
  wire [OFS_RANGE_W-1:0] range_w = cur_cfg_reg[OFS_CUR_RANGE_LSB +: OFS_RANGE_W];
  wire [1:0] cur_opt_w = cur_cfg_reg[OFS_CUR_OPT_LSB +: 2];
  wire [1:0] pul_opt_w = pf_cfg_reg[OFS_PF_PULSE_LSB +: 2];
  wire [1:0] frq_opt_w = pf_cfg_reg[OFS_PF_FREQ_LSB +: 2];

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  wire a_cur = hit(paddr, OFS_ADDR_CUR_CFG);
  wire a_pf  = hit(paddr, OFS_ADDR_PF_CFG);
  wire a_sf  = hit(paddr, OFS_ADDR_SUBST_FRQ);
  wire a_ct  = hit(paddr, OFS_ADDR_CTRL);
  wire a_st  = hit(paddr, OFS_ADDR_STATUS);
  wire a_is  = hit(paddr, OFS_ADDR_IRQ_STAT);
  wire a_ie  = hit(paddr, OFS_ADDR_IRQ_EN);
  wire a_ic  = hit(paddr, OFS_ADDR_IRQ_CLR);
  wire a_lo  = hit(paddr, OFS_ADDR_ALARM_LO);
  wire a_hi  = hit(paddr, OFS_ADDR_ALARM_HI);
  wire mapped = a_cur | a_pf | a_sf | a_ct | a_st | a_is | a_ie | a_ic | a_lo | a_hi;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ************************************************************
  // write strobes
  // ************************************************************
  // one strobe per register keeps each always_ff to a single field, except the alarm block, which holds both the lo and hi levels
  wire wr_cur = wr_en && a_cur;
  wire wr_pf  = wr_en && a_pf;
  wire wr_sf  = wr_en && a_sf;
  wire wr_ct  = wr_en && a_ct;
  wire wr_ie  = wr_en && a_ie;
  wire wr_ic  = wr_en && a_ic;
  wire wr_lo  = wr_en && a_lo;
  wire wr_hi  = wr_en && a_hi;
  wire [OFS_RANGE_W-1:0] wr_idx = pwdata[OFS_ALARM_IDX_LSB +: OFS_RANGE_W];

  // ************************************************************
  // failsafe qualification
  // ************************************************************
  // notice class and no-error both count as healthy
  wire fail_act = (err_sev == OFS_SEV_FAULT) || (err_sev == OFS_SEV_SYSTEM);
  wire zero_ret = zero_ret_in || ctrl_reg[OFS_CTRL_ZR_BIT];
  wire sim_en   = ctrl_reg[OFS_CTRL_SIM_BIT] && !zero_ret;

  wire [CUR_W-1:0] cur_fail = (cur_opt_w == OFS_CUR_HIGH_ALARM) ? alarm_hi_reg[range_w]
                                                                 : alarm_lo_reg[range_w];
  // remap current options onto the shared channel encoding
  wire [1:0] cur_chan_opt = (cur_opt_w == OFS_CUR_FREEZE)    ? OFS_FREEZE :
                            (cur_opt_w == OFS_CUR_PASS_LIVE) ? OFS_PASS_LIVE :
                            OFS_GO_DEFAULT;
  wire [FREQ_W-1:0] frq_fail = (frq_opt_w == OFS_FIXED_FREQ) ? subst_frq_reg
                                                             : '0;
  // fixed frequency is meaningless for pulses, treated as go_default
  wire [1:0] pul_chan_opt = (pul_opt_w == OFS_FIXED_FREQ) ? OFS_GO_DEFAULT : pul_opt_w;

  // ************************************************************
  // output channels
  // ************************************************************
  ofs_chan #(.W(CUR_W)) u_cur (
    .pclk     (pclk),
    .presetn  (presetn),
    .live_val (cur_live),
    .fail_val (cur_fail),
    .sim_val  (alarm_hi_reg[range_w]),
    .zero_val (cur_zero),
    .sim_en   (sim_en),
    .fail_act (fail_act),
    .zero_ret (zero_ret),
    .opt      (cur_chan_opt),
    .out_val  (cur_out)
  );

  ofs_chan #(.W(FREQ_W)) u_frq (
    .pclk     (pclk),
    .presetn  (presetn),
    .live_val (freq_live),
    .fail_val (frq_fail),
    .sim_val  (subst_frq_reg),
    .zero_val ('0),
    .sim_en   (sim_en),
    .fail_act (fail_act),
    .zero_ret (zero_ret),
    .opt      (frq_opt_w),
    .out_val  (freq_out)
  );

  ofs_chan #(.W(1)) u_pul (
    .pclk     (pclk),
    .presetn  (presetn),
    .live_val (pulse_live),
    .fail_val (1'b0),
    .sim_val  (1'b0),
    .zero_val (1'b0),
    .sim_en   (sim_en),
    .fail_act (fail_act),
    .zero_ret (zero_ret),
    .opt      (pul_chan_opt),
    .out_val  (pulse_out)
  );

  // ************************************************************
  // relay and fieldbus
  // ************************************************************
  // relay ignores zero-return entirely
  wire relay_next = relay_req && !fail_act && supply_ok;
  wire [FB_W-1:0] fb_next = zero_ret ? '0 : fb_live;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_reg <= 1'b0;
    end else begin
      relay_reg <= relay_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_reg <= '0;
    end else begin
      fb_reg <= fb_next;
    end
  end

  assign relay_out = relay_reg;
  assign fb_out    = fb_reg;

  // ************************************************************
  // configuration writes
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_cfg_reg <= OFS_CUR_CFG_RST;
    end else if (wr_cur) begin
      cur_cfg_reg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_cfg_reg <= OFS_PF_CFG_RST;
    end else if (wr_pf) begin
      pf_cfg_reg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subst_frq_reg <= '0;
    end else if (wr_sf) begin
      subst_frq_reg <= pwdata[FREQ_W-1:0];
    end
  end

  // a software override stays in force until software lifts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
    end else if (wr_ct) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= '0;
    end else if (wr_ie) begin
      irq_en_reg <= pwdata[OFS_IRQ_W-1:0];
    end
  end

  // alarm levels per range: level in the low bits, range index in the top bits
  genvar gi;
  generate
    for (gi = 0; gi < OFS_N_RANGE; gi++) begin : g_alarm
      wire sel_g = (wr_idx == OFS_RANGE_W'(gi));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          alarm_lo_reg[gi] <= '0;
          alarm_hi_reg[gi] <= '1;
        end else begin
          if (sel_g && wr_lo) alarm_lo_reg[gi] <= pwdata[CUR_W-1:0];
          if (sel_g && wr_hi) alarm_hi_reg[gi] <= pwdata[CUR_W-1:0];
        end
      end
    end
  endgenerate

  // ************************************************************
  // events and interrupt
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_d_reg <= 1'b0;
    end else begin
      fail_d_reg <= fail_act;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zr_d_reg <= 1'b0;
    end else begin
      zr_d_reg <= zero_ret;
    end
  end

  wire [OFS_IRQ_W-1:0] ev_w  = {zero_ret && !zr_d_reg, !fail_act && fail_d_reg, fail_act && !fail_d_reg};
  wire [OFS_IRQ_W-1:0] clr_w = wr_ic ? pwdata[OFS_IRQ_W-1:0] : '0;

  ofs_irq #(.N(OFS_IRQ_W)) u_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .ev       (ev_w),
    .clr      (clr_w),
    .en       (irq_en_reg),
    .stat_reg (irq_stat),
    .irq      (irq)
  );

  // ************************************************************
  // read mux
  // ************************************************************
  wire [31:0] st_w = {27'h0, relay_reg, sim_en, zero_ret, err_sev};
  wire [CUR_W-1:0] lo_rd = alarm_lo_reg[range_w];
  wire [CUR_W-1:0] hi_rd = alarm_hi_reg[range_w];
  wire [31:0] cur_rd_w = {28'h0, cur_cfg_reg};
  wire [31:0] pf_rd_w  = {28'h0, pf_cfg_reg};
  wire [31:0] sf_rd_w  = 32'(subst_frq_reg);
  wire [31:0] ct_rd_w  = {30'h0, ctrl_reg};
  wire [31:0] is_rd_w  = 32'(irq_stat);
  wire [31:0] ie_rd_w  = 32'(irq_en_reg);
  wire [31:0] lo_rd_w  = 32'(lo_rd);
  wire [31:0] hi_rd_w  = 32'(hi_rd);

  // decodes are one-hot, so an and-or tree is enough; unmapped reads give zero
  wire [31:0] rd_word = ({32{a_cur}} & cur_rd_w) |
                        ({32{a_pf}}  & pf_rd_w)  |
                        ({32{a_sf}}  & sf_rd_w)  |
                        ({32{a_ct}}  & ct_rd_w)  |
                        ({32{a_st}}  & st_w)     |
                        ({32{a_is}}  & is_rd_w)  |
                        ({32{a_ie}}  & ie_rd_w)  |
                        ({32{a_lo}}  & lo_rd_w)  |
                        ({32{a_hi}}  & hi_rd_w);

  // registered so the word stands unchanged through the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else begin
      prdata_reg <= rd_en ? rd_word : 32'h0;
    end
  end

  assign prdata = prdata_reg;

endmodule // ofs_selector
